// file: hw/tcc_pkg.sv
// Constants for the timer capture/compare unit
package tcc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CAP_EDGE = 8'hE8;
  localparam logic [7:0] IDX_CTRL = 8'hEA;
  localparam logic [7:0] IDX_FLAGS = 8'hEB;
  localparam logic [7:0] IDX_COUNT = 8'hEC;
  localparam logic [7:0] IDX_PORT = 8'hED;
  localparam logic [7:0] IDX_SET_EN = 8'hEE;
  localparam logic [7:0] IDX_CLR_TGL = 8'hEF;
  localparam logic [7:0] IDX_CAPT0 = 8'hF0;
  localparam logic [7:0] IDX_CMP0 = 8'hF4;
  localparam int ADDR_W = 12;
  // Control register fields
  localparam int CTRL_SRC = 0;
  localparam int CTRL_PRE = 2;
  localparam int CTRL_LOW_FLAG = 4;
  localparam int CTRL_EXT_RST_EN = 5;
  localparam int CTRL_LOW_IRQ_SEL = 6;
  localparam int CTRL_WRAP_IRQ_SEL = 7;
  // Flag register fields
  localparam int FLG_CAP0 = 0;
  localparam int FLG_CMP0 = 4;
  localparam int FLG_WRAP = 7;
  // Port fields
  localparam int PORT_TGL_LO = 6;
  // Source codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_DIV12 = 2'h1;
  localparam logic [1:0] SRC_TEST = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam int EXT_MIN_PERIOD_CYC = 12;
  // Reset values and response codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hw/tcc_timer.sv
// Timer capture/compare unit with AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer (
  input wire logic clk_i, // 20 MHz clock
  input wire logic rstn_i, // Chip reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic ext_clk_i, // External count clock
  input wire logic counter_ext_reset_in_i, // External counter reset
  input wire logic [3:0] capture_in_i, // Capture inputs 0-3
  input wire logic idle_i, // Idle or power-down state
  output logic [7:0] compare_output_port_o, // Compare output port
  output logic overflow_irq_o // Shared overflow request
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  function automatic logic idx_ok(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    idx_ok = (a[11:10] == 2'h0) &&
      ((i >= tcc_pkg::IDX_CAP_EDGE && i <= tcc_pkg::IDX_CLR_TGL &&
        i != 8'hE9) ||
       (i >= tcc_pkg::IDX_CAPT0 && i <= 8'hF6));
  endfunction

  logic [7:0] cap_edge;
  logic [7:0] ctrl;
  logic [7:0] flags;
  logic [7:0] set_en;
  logic [7:0] clr_tgl_en;
  logic [7:0] port_q;
  logic [15:0] count;
  logic [15:0] capt [4];
  logic [15:0] cmp [3];
  logic [2:0] pre;
  logic [3:0] div12;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic aw_hold;
  logic w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] widx;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign widx = aw_addr[9:2];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_awready <= 1'b0;
      aw_hold <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (do_write) begin
        aw_hold <= 1'b0;
      end
      s_axi_awready <= !aw_hold && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_wready <= 1'b0;
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (do_write) begin
        w_hold <= 1'b0;
      end
      s_axi_wready <= !w_hold && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcc_pkg::RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= idx_ok(aw_addr) ? tcc_pkg::RESP_OK :
        tcc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane write strobes per register
  logic wr_lo;
  logic wr_hi;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_port;
  logic wr_set;
  assign wr_lo = do_write && w_strb[0] && idx_ok(aw_addr);
  assign wr_hi = do_write && w_strb[1] && idx_ok(aw_addr);
  assign wr_ctrl = wr_lo && widx == tcc_pkg::IDX_CTRL;
  assign wr_flags = wr_lo && widx == tcc_pkg::IDX_FLAGS;
  assign wr_port = wr_lo && widx == tcc_pkg::IDX_PORT;
  assign wr_set = wr_lo && widx == tcc_pkg::IDX_SET_EN;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  function automatic logic [15:0] read_mux(input logic [7:0] i);
    read_mux = 16'h0000;
    if (i == tcc_pkg::IDX_CAP_EDGE) read_mux = {8'h00, cap_edge};
    if (i == tcc_pkg::IDX_CTRL) read_mux = {8'h00, ctrl};
    if (i == tcc_pkg::IDX_FLAGS) read_mux = {8'h00, flags};
    if (i == tcc_pkg::IDX_COUNT) read_mux = count;
    if (i == tcc_pkg::IDX_PORT) read_mux = {8'h00, port_q};
    if (i == tcc_pkg::IDX_SET_EN) read_mux = {8'h00, set_en};
    if (i == tcc_pkg::IDX_CLR_TGL) read_mux = {8'h00, clr_tgl_en};
    for (int k = 0; k < 4; k++) begin
      if (i == tcc_pkg::IDX_CAPT0 + 8'(k)) read_mux = capt[k];
    end
    for (int k = 0; k < 3; k++) begin
      if (i == tcc_pkg::IDX_CMP0 + 8'(k)) read_mux = cmp[k];
    end
  endfunction

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tcc_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, read_mux(s_axi_araddr[9:2])};
      s_axi_rresp <= idx_ok(s_axi_araddr) ? tcc_pkg::RESP_OK :
        tcc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Stage 1 feeds stage 2 only; edges come from stages 2 and 3
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [5:0] sy3;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sy1 <= 6'h00;
      sy2 <= 6'h00;
      sy3 <= 6'h00;
    end else begin
      sy1 <= {counter_ext_reset_in_i, ext_clk_i, capture_in_i};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end
  logic [5:0] rise;
  logic [5:0] fall;
  assign rise = sy2 & ~sy3;
  assign fall = ~sy2 & sy3;

  // ****************************************************************
  // Prescaler and counter
  // ****************************************************************
  logic [1:0] src;
  logic [1:0] psel;
  logic src_tick;
  logic pre_last;
  logic cnt_tick;
  logic cnt_clr;
  logic ext_rst_ev;
  logic cfg_change;
  logic low_ev;
  logic full_ev;
  assign src = ctrl[tcc_pkg::CTRL_SRC +: 2];
  assign psel = ctrl[tcc_pkg::CTRL_PRE +: 2];
  // Test code counts nothing
  assign src_tick = (src == tcc_pkg::SRC_DIV12 &&
    div12 == tcc_pkg::DIV12_LAST) ||
    (src == tcc_pkg::SRC_EXT && rise[4]);
  assign pre_last = pre == 3'((4'h1 << psel) - 4'h1);
  assign ext_rst_ev = ctrl[tcc_pkg::CTRL_EXT_RST_EN] && rise[5];
  assign cnt_clr = idle_i || ext_rst_ev;
  assign cfg_change = wr_ctrl && (w_data[3:0] != ctrl[3:0]);
  assign cnt_tick = src_tick && pre_last && !cnt_clr;
  assign low_ev = cnt_tick && count[7:0] == 8'hFF;
  assign full_ev = cnt_tick && count == 16'hFFFF;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div12 <= 4'h0;
    end else if (idle_i || src != tcc_pkg::SRC_DIV12 ||
                 div12 == tcc_pkg::DIV12_LAST) begin
      div12 <= 4'h0;
    end else begin
      div12 <= div12 + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre <= 3'h0;
    end else if (cfg_change || cnt_clr) begin
      pre <= 3'h0;
    end else if (src_tick) begin
      pre <= pre_last ? 3'h0 : pre + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= tcc_pkg::RST_WORD;
    end else if (cnt_clr) begin
      count <= tcc_pkg::RST_WORD;
    end else if (cnt_tick) begin
      count <= count + 16'h0001;
    end
  end

  // ****************************************************************
  // Capture
  // ****************************************************************
  logic [3:0] cap_ev;
  for (genvar g = 0; g < 4; g++) begin : g_cap
    assign cap_ev[g] = (cap_edge[2*g] && rise[g]) ||
      (cap_edge[2*g+1] && fall[g]);
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        capt[g] <= tcc_pkg::RST_WORD;
      end else if (cap_ev[g]) begin
        capt[g] <= count;
      end
    end
  end

  // ****************************************************************
  // Compare
  // ****************************************************************
  // Acts on the cycle equality begins, so a halted count fires once
  logic [2:0] eq;
  logic [2:0] eq_d;
  logic [2:0] cmp_ev;
  for (genvar g = 0; g < 3; g++) begin : g_cmp
    assign eq[g] = count == cmp[g];
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cmp[g] <= tcc_pkg::RST_WORD;
      end else if (do_write && idx_ok(aw_addr) &&
                   widx == tcc_pkg::IDX_CMP0 + 8'(g)) begin
        if (wr_lo) begin
          cmp[g][7:0] <= w_data[7:0];
        end
        if (wr_hi) begin
          cmp[g][15:8] <= w_data[15:8];
        end
      end
    end
  end
  assign cmp_ev = eq & ~eq_d;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eq_d <= 3'h7;
    end else begin
      eq_d <= eq;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cap_edge <= tcc_pkg::RST_BYTE;
      clr_tgl_en <= tcc_pkg::RST_BYTE;
    end else begin
      if (wr_lo && widx == tcc_pkg::IDX_CAP_EDGE) begin
        cap_edge <= w_data[7:0];
      end
      if (wr_lo && widx == tcc_pkg::IDX_CLR_TGL) begin
        clr_tgl_en <= w_data[7:0];
      end
    end
  end

  // Toggle state bits flip on each toggle; hardware beats a write
  logic [1:0] tgl_do;
  assign tgl_do = {2{cmp_ev[2]}} & clr_tgl_en[7:6];
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      set_en <= tcc_pkg::RST_BYTE;
    end else begin
      if (wr_set) begin
        set_en <= w_data[7:0];
      end
      for (int k = 0; k < 2; k++) begin
        if (tgl_do[k]) begin
          set_en[tcc_pkg::PORT_TGL_LO + k] <=
            !set_en[tcc_pkg::PORT_TGL_LO + k];
        end
      end
    end
  end

  // ****************************************************************
  // Flags and overflow request
  // ****************************************************************
  // Software clears by writing 0; a same-cycle event still sets
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags <= tcc_pkg::RST_BYTE;
    end else begin
      flags <= (wr_flags ? w_data[7:0] : flags) |
        {full_ev, cmp_ev, cap_ev};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= tcc_pkg::RST_BYTE;
    end else begin
      ctrl <= wr_ctrl ? w_data[7:0] : ctrl;
      if (low_ev) begin
        ctrl[tcc_pkg::CTRL_LOW_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overflow_irq_o <= 1'b0;
    end else begin
      overflow_irq_o <=
        (flags[tcc_pkg::FLG_WRAP] && ctrl[tcc_pkg::CTRL_WRAP_IRQ_SEL]) ||
        (ctrl[tcc_pkg::CTRL_LOW_FLAG] &&
         ctrl[tcc_pkg::CTRL_LOW_IRQ_SEL]);
    end
  end

  // ****************************************************************
  // Output port
  // ****************************************************************
  logic [7:0] next_port;
  always_comb begin
    next_port = wr_port ? w_data[7:0] : port_q;
    if (cmp_ev[0]) begin
      next_port[5:0] = next_port[5:0] | set_en[5:0];
    end
    if (cmp_ev[1]) begin
      next_port[5:0] = next_port[5:0] & ~clr_tgl_en[5:0];
    end
    for (int k = 0; k < 2; k++) begin
      if (tgl_do[k]) begin
        next_port[tcc_pkg::PORT_TGL_LO + k] =
          !set_en[tcc_pkg::PORT_TGL_LO + k];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_q <= tcc_pkg::RST_BYTE;
      compare_output_port_o <= tcc_pkg::RST_BYTE;
    end else begin
      port_q <= next_port;
      compare_output_port_o <= next_port;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_both_match;
    cmp_ev[0] && cmp_ev[1] && set_en[0] && clr_tgl_en[0];
  endsequence
  sequence s_set_only;
    cmp_ev[0] && !cmp_ev[1] && set_en[0];
  endsequence

  a_count_step: assert property (cnt_tick |=>
    count == $past(count) + 16'h0001)
    else $error("count did not step");
  a_ext_reset_clear: assert property (ext_rst_ev |=>
    count == 16'h0000 && pre == 3'h0)
    else $error("external reset did not clear");
  a_idle_hold: assert property (idle_i [*2] |->
    count == 16'h0000 && pre == 3'h0)
    else $error("idle did not hold counter");
  a_capture_load: assert property (cap_ev[0] |=>
    capt[0] == $past(count) && flags[0])
    else $error("capture 0 not loaded");
  a_no_edge_sel: assert property (cap_edge[1:0] == 2'h0 |->
    !cap_ev[0])
    else $error("capture without edge select");
  a_clear_wins: assert property (s_both_match |=>
    !compare_output_port_o[0])
    else $error("clear did not win");
  a_set_port: assert property (s_set_only |=>
    compare_output_port_o[0])
    else $error("set action missed");
  a_toggle_dir: assert property (tgl_do[0] |=>
    compare_output_port_o[6] == !$past(set_en[6]) &&
    set_en[6] != $past(set_en[6]))
    else $error("toggle wrong");
  a_flag_sticky: assert property (flags[4] && !wr_flags |=>
    flags[4])
    else $error("flag lost");
  a_wrap_flag: assert property (full_ev |=>
    flags[7] && ctrl[4] && count == 16'h0000)
    else $error("wrap flags missing");
  a_pre_cfg: assert property (cfg_change |=> pre == 3'h0)
    else $error("prescaler not cleared");
  a_write_resp: assert property (do_write |=> s_axi_bvalid [*1]
    ##0 (!aw_hold && !w_hold))
    else $error("write not answered");

endmodule
`default_nettype wire

// file: testbench/tcc_pins_model.sv
// Pin-side model: external count clock, counter reset and capture pins
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
  input wire logic clk_i, // System clock
  output logic ext_clk_o, // External count clock
  output logic ext_rst_o, // External counter reset
  output logic [3:0] cap_o // Capture pins
);
  // ************************
  // Pin drivers
  // ************************
  // Clock stands low between bursts; input 1 starts high for a fall
  initial begin
    ext_clk_o = 1'b0;
    ext_rst_o = 1'b0;
    cap_o = 4'h2;
  end
  // Twelve-clock period, the fastest the far side may run
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask
  task automatic rst_pulse();
    @(posedge clk_i);
    ext_rst_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_rst_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic set_cap(input logic [3:0] v);
    @(posedge clk_i);
    cap_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: testbench/tcc_timer_tb.sv
// Self-checking bench for the timer capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_tb;
  logic clk_i, rstn_i, idle_i, ext_clk_i, counter_ext_reset_in_i;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb, capture_in_i;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, overflow_irq_o;
  logic [7:0] compare_output_port_o;
  int failures, n_checks;
  tcc_timer i_tcc_timer (.clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_i,
    .counter_ext_reset_in_i, .capture_in_i, .idle_i,
    .compare_output_port_o, .overflow_irq_o);
  tcc_pins_model i_tcc_pins_model (.clk_i, .ext_clk_o(ext_clk_i),
    .ext_rst_o(counter_ext_reset_in_i), .cap_o(capture_in_i));
  // ************************
  // Bus tasks and checks
  // ************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clk_i);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    rr_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(rd_q, exp);
  endtask
  // Port changes one edge after the match; allow it to land
  task automatic pin(input logic [7:0] exp);
    repeat (2) @(posedge clk_i);
    chk({24'h0, compare_output_port_o}, {24'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ************************
  // Scenarios
  // ************************
  task automatic t_reset();
    logic [7:0] r [9] = '{8'hE8, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE,
      8'hEF, 8'hF0, 8'hF4};
    for (int i = 0; i < 9; i++) rc(r[i], 32'h0);
    rd(8'h10);
    chk({30'h0, rr_q}, {30'h0, tcc_pkg::RESP_SLVERR});
  endtask
  task automatic t_count();
    logic [31:0] c;
    wr(tcc_pkg::IDX_CTRL, 32'h03);
    i_tcc_pins_model.pulses(5);
    rc(tcc_pkg::IDX_COUNT, 32'h5);
    wr(tcc_pkg::IDX_CTRL, 32'h0B);
    i_tcc_pins_model.pulses(8);
    rc(tcc_pkg::IDX_COUNT, 32'h7);
    wr(tcc_pkg::IDX_CTRL, 32'h01);
    repeat (96) @(posedge clk_i);
    wr(tcc_pkg::IDX_CTRL, 32'h02);
    rd(tcc_pkg::IDX_COUNT);
    c = rd_q;
    chk({31'h0, c > 32'hD && c < 32'h11}, 32'h1);
    i_tcc_pins_model.pulses(2);
    wr(tcc_pkg::IDX_COUNT, 32'h1234);
    rc(tcc_pkg::IDX_COUNT, c);
  endtask
  task automatic t_wrap();
    wr(tcc_pkg::IDX_CTRL, 32'h63);
    i_tcc_pins_model.rst_pulse();
    rc(tcc_pkg::IDX_COUNT, 32'h0);
    chk({31'h0, overflow_irq_o}, 32'h0);
    i_tcc_pins_model.pulses(256);
    rc(tcc_pkg::IDX_COUNT, 32'h100);
    rc(tcc_pkg::IDX_CTRL, 32'h73);
    chk({31'h0, overflow_irq_o}, 32'h1);
    wr(tcc_pkg::IDX_CTRL, 32'h20);
    repeat (2) @(posedge clk_i);
    chk({31'h0, overflow_irq_o}, 32'h0);
  endtask
  task automatic t_capture();
    wr(tcc_pkg::IDX_CAP_EDGE, 32'h09);
    i_tcc_pins_model.set_cap(4'h5);
    rc(tcc_pkg::IDX_CAPT0, 32'h100);
    rc(tcc_pkg::IDX_CAPT0 + 8'h1, 32'h100);
    rc(tcc_pkg::IDX_CAPT0 + 8'h2, 32'h0);
    // Clearing the count to zero matched all three zeroed compares
    rc(tcc_pkg::IDX_FLAGS, 32'h73);
    wr(tcc_pkg::IDX_FLAGS, 32'h0);
    rc(tcc_pkg::IDX_FLAGS, 32'h0);
  endtask
  task automatic t_compare();
    wr(tcc_pkg::IDX_SET_EN, 32'h3F);
    wr(tcc_pkg::IDX_CLR_TGL, 32'hFF);
    wr(tcc_pkg::IDX_CMP0, 32'h100);
    pin(8'h3F);
    wr(tcc_pkg::IDX_CMP0 + 8'h1, 32'h100);
    pin(8'h00);
    wr(tcc_pkg::IDX_SET_EN, 32'hBF);
    wr(tcc_pkg::IDX_CMP0 + 8'h2, 32'h100);
    pin(8'h40);
    rc(tcc_pkg::IDX_SET_EN, 32'h7F);
    rc(tcc_pkg::IDX_FLAGS, 32'h70);
    wr(tcc_pkg::IDX_PORT, 32'h3F);
    pin(8'h3F);
    wr(tcc_pkg::IDX_CMP0, 32'h101);
    wr(tcc_pkg::IDX_CMP0 + 8'h1, 32'h101);
    wr(tcc_pkg::IDX_CTRL, 32'h03);
    i_tcc_pins_model.pulses(1);
    pin(8'h00);
  endtask
  task automatic t_idle();
    @(posedge clk_i);
    idle_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(tcc_pkg::IDX_COUNT, 32'h0);
    idle_i <= 1'b0;
    // Low lane only: compare 2 keeps its high byte
    s_axi_wstrb <= 4'h1;
    wr(tcc_pkg::IDX_CMP0 + 8'h2, 32'h0000_5555);
    s_axi_wstrb <= 4'hF;
    rc(tcc_pkg::IDX_CMP0 + 8'h2, 32'h0155);
  endtask
  // ************************
  // Main sequence and watchdog
  // ************************
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, idle_i} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    rstn_i = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_count();
    t_wrap();
    t_capture();
    t_compare();
    t_idle();
    end_of_test();
  end
  // Whole run needs about 4000 clocks
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
